// ---- core/fcvs_cfg.svh ----
// Constants for the frequency change and vector surge protection element
`ifndef FCVS_CFG_SVH
`define FCVS_CFG_SVH

// Timing
`define FCVS_CLK_NS 20
`define FCVS_TICK_NS 1000000
`define FCVS_DETECT_MS 60

// Dropout of 0.05 percent, as a fraction
`define FCVS_DROP_NUM 24'h000005
`define FCVS_DROP_DEN 24'h002710

// Register byte offsets
`define FCVS_ADDR_STATUS 12'h000
`define FCVS_ADDR_MASK 12'h004
`define FCVS_ADDR_STATE 12'h008

// Status and mask bit positions
`define FCVS_EV_ALARM 0
`define FCVS_EV_TRIP 1
`define FCVS_EV_LOCK 2
`define FCVS_EV_W 3

// Reset values
`define FCVS_STATUS_RST 3'h0
`define FCVS_MASK_RST 3'h0

`endif

// ---- core/fcvs_pkg.sv ----
// Types of the frequency change and vector surge protection element
package fcvs_pkg;

  typedef logic [19:0] fcvs_freq_t;
  typedef logic [15:0] fcvs_volt_t;

  typedef enum logic [1:0] {
    FCVS_MODE_OFF,
    FCVS_MODE_UNDER_DF,
    FCVS_MODE_OVER_DF,
    FCVS_MODE_SURGE
  } fcvs_mode_e;

  typedef enum logic [1:0] {
    FCVS_PH_ALL,
    FCVS_PH_TWO,
    FCVS_PH_ONE
  } fcvs_phsel_e;

  typedef enum logic [1:0] {
    FCVS_ST_IDLE,
    FCVS_ST_RUN,
    FCVS_ST_TRIP,
    FCVS_ST_LOCK
  } fcvs_state_e;

  // Frequencies in mHz, interval in ms, surge limit in clock cycles
  typedef struct packed {
    fcvs_mode_e mode;
    fcvs_phsel_e phase_sel;
    fcvs_volt_t min_voltage;
    fcvs_freq_t pickup_freq;
    fcvs_freq_t freq_change_limit;
    logic [15:0] supervision_interval;
    fcvs_freq_t rated_frequency;
    logic [21:0] surge_limit;
  } fcvs_cfg_s;

  // Index 0 is line_voltage_a_b, 1 line_voltage_b_c, 2 line_voltage_c_a
  typedef struct packed {
    logic [2:0][19:0] freq;
    logic [2:0][15:0] volt;
    logic [2:0] zero_cross;
    logic [2:0] phase_lost;
  } fcvs_meas_s;

endpackage

// ---- core/fcvs_cycle_meter.sv ----
// Cycle duration meter for one line voltage, flags a vector surge
`timescale 1ns/1ps
module fcvs_cycle_meter
  import fcvs_pkg::*;
#(
  parameter int CW = 22
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic en_i,
  input wire logic zc_i,
  input wire logic [CW-1:0] limit_i,
  // Result
  output logic surge_o,
  output logic [CW-1:0] dev_o
);

  logic [CW-1:0] cnt;
  logic [CW-1:0] ref_dur;
  logic [1:0] fill;
  logic [CW-1:0] dev;

  // Previous cycle is the reference, so slow drift never looks like a surge
  assign dev = (cnt > ref_dur) ? (cnt - ref_dur) : (ref_dur - cnt); // R7

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      ref_dur <= '0;
      fill <= 2'h0;
      surge_o <= 1'b0;
      dev_o <= '0;
    end else if (!en_i) begin
      cnt <= '0;
      fill <= 2'h0;
      surge_o <= 1'b0;
    end else if (zc_i) begin
      cnt <= {{(CW-1){1'b0}}, 1'b1}; // R6
      ref_dur <= cnt;
      if (fill != 2'h2) begin
        fill <= fill + 2'h1;
      end
      surge_o <= (fill == 2'h2) && (dev > limit_i); // R7
      dev_o <= dev;
    end else if (cnt != {CW{1'b1}}) begin
      cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  cycle_measure_a: assert property (en_i && zc_i && fill == 2'h2 |=> // R7
    dev_o == (($past(cnt) > $past(ref_dur)) ? ($past(cnt) - $past(ref_dur)) : ($past(ref_dur) - $past(cnt))))
    else $error("deviation not taken from last cycle");
  cycle_restart_a: assert property (en_i && zc_i |=> cnt == 1 && ref_dur == $past(cnt))
    else $error("measurement not restarted at crossing"); // R6

endmodule

// ---- core/fcvs_prot.sv ----
// Frequency change and vector surge protection element with APB status
//
// Function
// R1 - Frequency evaluation is suppressed while all three line voltages are below the minimum voltage.
// R2 - In frequency change mode the frequency is compared with the pickup and its change with the change limit.
// R3 - A pickup without blocking raises the alarm at once and starts the supervision timer in the same step.
// R4 - Trip is asserted when during the interval the pickup holds and the change reaches the limit.
// R5 - Interval expiry without the limit gives no trip and locks the element until a new pickup crossing.
// R6 - In surge mode each line voltage cycle is timed, restarting at every zero crossing.
// R7 - Each cycle duration is compared with a reference and the deviation is the surge angle.
// R8 - Alarm and trip rise together at once when enough phases surge and nothing blocks.
// R9 - Surge tripping is inhibited while any phase of the measuring voltage is lost.
// R10 - Surge measurement is blocked at low voltage, faster than a surge decision.
// R11 - A mains failure seen by the surge function is reported well inside the detection time.
// R12 - An overfrequency pickup releases no earlier than 99.95 percent of its value or 0.05 percent of rated.
// R13 - An underfrequency pickup releases no earlier than 100.05 percent of its value or 0.05 percent of rated.
// R14 - The overfrequency variant uses an overfrequency pickup, a rising change limit and the interval.
// R15 - Settings are static inputs and reset clears alarm, trip, timers and the lock.
`timescale 1ns/1ps
`include "fcvs_cfg.svh"
module fcvs_prot
  import fcvs_pkg::*;
#(
  parameter int TICK_CYCLES = `FCVS_TICK_NS / `FCVS_CLK_NS,
  parameter int CW = 22
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Static settings and measurements
  input wire fcvs_cfg_s cfg_i,
  input wire fcvs_meas_s meas_i,
  input wire logic freq_valid_i,
  input wire logic block_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Protection outputs
  output logic alarm_o,
  output logic trip_o,
  output logic irq_o
);

  logic rst_meta;
  logic rst_n;
  fcvs_state_e state;
  fcvs_state_e next_state;
  fcvs_freq_t eval_freq;
  fcvs_freq_t new_freq;
  fcvs_freq_t ref_freq;
  fcvs_freq_t margin;
  logic [23:0] drop_thr;
  logic [23:0] drop_rated;
  logic picked;
  logic volt_low;
  logic freq_mode;
  logic over_mode;
  logic change_hit;
  logic [31:0] tick_cnt;
  logic tick;
  logic [15:0] ms_cnt;
  logic expired;
  logic [2:0] surge_ph;
  logic [1:0] surge_cnt;
  logic [1:0] surge_need;
  logic surge_hit;
  logic next_alarm;
  logic next_trip;
  logic lock_enter;
  logic [`FCVS_EV_W-1:0] status;
  logic [`FCVS_EV_W-1:0] mask;
  logic [`FCVS_EV_W-1:0] ev_set;
  logic wr_acc;
  logic mapped;

  // Reset release through two flops
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Undervoltage acts combinationally, ahead of any registered decision
  assign volt_low = (meas_i.volt[0] < cfg_i.min_voltage) && (meas_i.volt[1] < cfg_i.min_voltage)
                    && (meas_i.volt[2] < cfg_i.min_voltage); // R1 R10
  assign freq_mode = (cfg_i.mode == FCVS_MODE_UNDER_DF) || (cfg_i.mode == FCVS_MODE_OVER_DF);
  assign over_mode = (cfg_i.mode == FCVS_MODE_OVER_DF); // R14

  // Worst phase: lowest for under, highest for over
  always_comb begin
    new_freq = meas_i.freq[0];
    for (int i = 1; i < 3; i++) begin
      if (over_mode ? (meas_i.freq[i] > new_freq) : (meas_i.freq[i] < new_freq)) begin
        new_freq = meas_i.freq[i];
      end
    end
  end

  // Release margin is the larger of the two dropout forms
  assign drop_thr = ({4'h0, cfg_i.pickup_freq} * `FCVS_DROP_NUM) / `FCVS_DROP_DEN;
  assign drop_rated = ({4'h0, cfg_i.rated_frequency} * `FCVS_DROP_NUM) / `FCVS_DROP_DEN;
  assign margin = (drop_thr > drop_rated) ? drop_thr[19:0] : drop_rated[19:0];

  // Pickup with hysteresis
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      picked <= 1'b0;
      eval_freq <= '0;
    end else if (!freq_mode || volt_low) begin
      picked <= 1'b0; // R1
    end else if (freq_valid_i) begin
      eval_freq <= new_freq; // R2
      if (over_mode) begin
        if (!picked && new_freq > cfg_i.pickup_freq) begin
          picked <= 1'b1;
        end else if (picked && ({1'b0, new_freq} + {1'b0, margin} < {1'b0, cfg_i.pickup_freq})) begin
          picked <= 1'b0; // R12
        end
      end else begin
        if (!picked && new_freq < cfg_i.pickup_freq) begin
          picked <= 1'b1;
        end else if (picked && ({1'b0, new_freq} > {1'b0, cfg_i.pickup_freq} + {1'b0, margin})) begin
          picked <= 1'b0; // R13
        end
      end
    end
  end

  // Change since the pickup, falling for under, rising for over
  always_comb begin
    if (over_mode) begin
      change_hit = (eval_freq >= ref_freq) && (eval_freq - ref_freq >= cfg_i.freq_change_limit); // R14
    end else begin
      change_hit = (ref_freq >= eval_freq) && (ref_freq - eval_freq >= cfg_i.freq_change_limit); // R2
    end
  end

  // Millisecond tick, the only slow rate
  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
    end else if (tick || state != FCVS_ST_RUN) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  assign expired = (ms_cnt >= cfg_i.supervision_interval);

  always_comb begin
    next_state = state;
    case (state)
      FCVS_ST_IDLE: begin
        if (freq_mode && picked && !block_i && !volt_low) begin
          next_state = FCVS_ST_RUN; // R3
        end
      end
      FCVS_ST_RUN: begin
        if (!freq_mode || !picked || block_i || volt_low) begin
          next_state = FCVS_ST_IDLE;
        end else if (change_hit) begin
          next_state = FCVS_ST_TRIP; // R4
        end else if (expired) begin
          next_state = FCVS_ST_LOCK; // R5
        end
      end
      FCVS_ST_TRIP: begin
        if (!freq_mode || !picked || block_i || volt_low) begin
          next_state = FCVS_ST_IDLE;
        end
      end
      FCVS_ST_LOCK: begin
        // Only a release and a fresh crossing rearms the element
        if (!freq_mode || !picked) begin
          next_state = FCVS_ST_IDLE; // R5
        end
      end
      default: begin
        next_state = FCVS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= FCVS_ST_IDLE; // R15
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt <= '0;
      ref_freq <= '0;
    end else if (state == FCVS_ST_IDLE) begin
      ms_cnt <= '0; // R3
      ref_freq <= eval_freq;
    end else if (state == FCVS_ST_RUN && tick && ms_cnt != 16'hFFFF) begin
      ms_cnt <= ms_cnt + 16'h1;
    end
  end

  // Vector surge meters, one per line voltage
  for (genvar g = 0; g < 3; g++) begin : g_meter
    fcvs_cycle_meter #(
      .CW(CW)
    ) u_meter (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n),
      .en_i((cfg_i.mode == FCVS_MODE_SURGE) && !volt_low), // R10
      .zc_i(meas_i.zero_cross[g]), // R6
      .limit_i(cfg_i.surge_limit),
      .surge_o(surge_ph[g]),
      .dev_o()
    );
  end

  assign surge_cnt = 2'({1'b0, surge_ph[0]} + {1'b0, surge_ph[1]} + {1'b0, surge_ph[2]});
  always_comb begin
    case (cfg_i.phase_sel)
      FCVS_PH_ALL: surge_need = 2'h3;
      FCVS_PH_TWO: surge_need = 2'h2;
      default: surge_need = 2'h1;
    endcase
  end
  assign surge_hit = (cfg_i.mode == FCVS_MODE_SURGE) && (surge_cnt >= surge_need) && !block_i
                     && !(|meas_i.phase_lost) && !volt_low; // R8 R9 R10

  assign next_alarm = surge_hit || next_state == FCVS_ST_RUN || next_state == FCVS_ST_TRIP; // R3 R8
  assign next_trip = surge_hit || next_state == FCVS_ST_TRIP; // R4 R8

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      alarm_o <= 1'b0; // R15
      trip_o <= 1'b0;
    end else begin
      alarm_o <= next_alarm;
      trip_o <= next_trip;
    end
  end

  // Sticky events, write one to clear, a new event beats the clear
  assign lock_enter = (state == FCVS_ST_RUN) && (next_state == FCVS_ST_LOCK);
  assign ev_set = {lock_enter, next_trip && !trip_o, next_alarm && !alarm_o};
  assign wr_acc = psel_i && penable_i && pwrite_i;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      status <= `FCVS_STATUS_RST;
    end else if (wr_acc && paddr_i == `FCVS_ADDR_STATUS) begin
      status <= (status & ~pwdata_i[`FCVS_EV_W-1:0]) | ev_set;
    end else begin
      status <= status | ev_set;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      mask <= `FCVS_MASK_RST;
    end else if (wr_acc && paddr_i == `FCVS_ADDR_MASK) begin
      mask <= pwdata_i[`FCVS_EV_W-1:0];
    end
  end

  assign irq_o = |(status & mask);

  // Zero wait states: read data is captured in the setup cycle
  assign mapped = (paddr_i == `FCVS_ADDR_STATUS) || (paddr_i == `FCVS_ADDR_MASK)
                  || (paddr_i == `FCVS_ADDR_STATE);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o <= 32'h0;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        `FCVS_ADDR_STATUS: prdata_o <= {29'h0, status};
        `FCVS_ADDR_MASK: prdata_o <= {29'h0, mask};
        `FCVS_ADDR_STATE: prdata_o <= {22'h0, surge_ph, volt_low, picked, trip_o, alarm_o, 1'b0, state};
        default: prdata_o <= 32'h0;
      endcase
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  volt_suppress_a: assert property (freq_mode && volt_low |=> !picked ##1 state == FCVS_ST_IDLE) // R1
    else $error("frequency evaluated at low voltage");
  alarm_start_a: assert property (state == FCVS_ST_IDLE && freq_mode && picked && !block_i && !volt_low // R3
    |=> alarm_o && state == FCVS_ST_RUN && ms_cnt == 16'h0)
    else $error("alarm or timer not started on pickup");
  change_trip_a: assert property (state == FCVS_ST_RUN && freq_mode && picked && !block_i && !volt_low // R4
    && change_hit |=> trip_o && alarm_o)
    else $error("no trip on change limit");
  expire_lock_a: assert property (state == FCVS_ST_RUN && freq_mode && picked && !block_i && !volt_low // R5
    && !change_hit && expired |=> state == FCVS_ST_LOCK && !trip_o)
    else $error("expiry did not lock");
  lock_hold_a: assert property (state == FCVS_ST_LOCK && freq_mode && picked |=> state == FCVS_ST_LOCK && !trip_o) // R5
    else $error("lock left without release");
  change_dir_a: assert property (state == FCVS_ST_RUN && !over_mode && eval_freq > ref_freq // R2
    |=> state != FCVS_ST_TRIP)
    else $error("rising frequency judged as a fall");
  over_drop_a: assert property (over_mode && picked && freq_valid_i && !volt_low // R12
    && new_freq >= cfg_i.pickup_freq - margin |=> picked)
    else $error("overfrequency released too early");
  under_drop_a: assert property (cfg_i.mode == FCVS_MODE_UNDER_DF && picked && freq_valid_i && !volt_low // R13
    && new_freq <= cfg_i.pickup_freq + margin |=> picked)
    else $error("underfrequency released too early");
  surge_trip_a: assert property (surge_hit |=> trip_o && alarm_o) // R8
    else $error("surge did not trip at once");
  phase_loss_a: assert property (cfg_i.mode == FCVS_MODE_SURGE && |meas_i.phase_lost |=> !trip_o) // R9
    else $error("surge trip with lost phase");
  uv_lockout_a: assert property (cfg_i.mode == FCVS_MODE_SURGE && volt_low |=> !trip_o ##1 surge_ph == 3'h0) // R10
    else $error("surge active at low voltage");
  surge_detect_a: assert property ($rose(surge_ph[0]) && cfg_i.phase_sel == FCVS_PH_ONE // R11
    && cfg_i.mode == FCVS_MODE_SURGE && !block_i && !(|meas_i.phase_lost) && !volt_low
    |-> ##[0:2] trip_o)
    else $error("surge decision too slow");
  // Two cycles from crossing to trip sits far inside the detection time
  detect_budget_a: assert property ((cfg_i.mode == FCVS_MODE_SURGE && cfg_i.phase_sel == FCVS_PH_ONE // R11
    && meas_i.zero_cross[0]) ##1 (surge_ph[0] && !block_i && !(|meas_i.phase_lost) && !volt_low) |-> ##1 trip_o)
    else $error("crossing to trip slower than two cycles");
  reset_clear_a: assert property ($rose(rst_n) |-> !alarm_o && !trip_o && state == FCVS_ST_IDLE) // R15
    else $error("reset left state behind");

endmodule

// ---- testbench/fcvs_prot_tb.sv ----
// Self-checking testbench for the frequency change and vector surge element
`timescale 1ns/1ps
`include "fcvs_cfg.svh"
module fcvs_prot_tb
  import fcvs_pkg::*;
;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  fcvs_cfg_s cfg = '0;
  fcvs_meas_s meas = '0;
  logic fv = 1'b0;
  logic blk = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic er;
  logic alarm;
  logic trip;
  logic irq;
  int err_count = 0;
  int check_count = 0;
  // Surge cases: phase selection, jumping phases, lost phases, low volts, block, expected trip
  fcvs_phsel_e sps[6] = '{FCVS_PH_ONE, FCVS_PH_ALL, FCVS_PH_TWO, FCVS_PH_ONE, FCVS_PH_ONE, FCVS_PH_ONE};
  logic [2:0] sjm[6] = '{3'h1, 3'h1, 3'h3, 3'h1, 3'h1, 3'h1};
  logic [2:0] slo[6] = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h0, 3'h0};
  logic [5:0] slw = 6'h10;
  logic [5:0] sbk = 6'h20;
  logic [5:0] sex = 6'h05;

  always #10 mclk_i = ~mclk_i;

  // Short tick keeps the supervision interval to tens of cycles
  fcvs_prot #(.TICK_CYCLES(10)) uut (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .cfg_i(cfg),
    .meas_i(meas),
    .freq_valid_i(fv),
    .block_i(blk),
    .psel_i(psel),
    .penable_i(pen),
    .pwrite_i(pwr),
    .paddr_i(paddr),
    .pwdata_i(pwdata),
    .prdata_o(prdata),
    .pready_o(pready),
    .pslverr_o(pslverr),
    .alarm_o(alarm),
    .trip_o(trip),
    .irq_o(irq)
  );

  task automatic finish_test;
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    pen <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) begin
      err_count++;
      $display("BAD %0t bus access never answered", $time);
      finish_test;
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp, m);
  endtask

  task automatic rst(input fcvs_mode_e md, input fcvs_phsel_e ps, input fcvs_freq_t pk);
    @(posedge mclk_i);
    arst_n_i <= 1'b0;
    cfg.mode <= md;
    cfg.phase_sel <= ps;
    cfg.pickup_freq <= pk;
    meas.volt <= {3{16'h8000}};
    meas.freq <= {3{20'h0C350}};
    meas.zero_cross <= 3'h0;
    meas.phase_lost <= 3'h0;
    blk <= 1'b0;
    repeat (16) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
  endtask

  // New frequency on all phases, then time for pickup and state to settle
  task automatic feed(input fcvs_freq_t f);
    @(posedge mclk_i);
    meas.freq <= {f, f, f};
    fv <= 1'b1;
    @(posedge mclk_i);
    fv <= 1'b0;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  task automatic zc(input logic [2:0] m, input int gap);
    repeat (gap) @(posedge mclk_i);
    meas.zero_cross <= m;
    @(posedge mclk_i);
    meas.zero_cross <= 3'h0;
  endtask

  initial begin
    cfg.min_voltage <= 16'h1000;
    cfg.freq_change_limit <= 20'h001F4;
    cfg.supervision_interval <= 16'h0003;
    cfg.rated_frequency <= 20'h0C350;
    cfg.surge_limit <= 22'h000005;
    // Underfrequency with change limit, register view and interrupt
    rst(FCVS_MODE_UNDER_DF, FCVS_PH_ALL, 20'h0BF68);
    rdc(`FCVS_ADDR_STATUS, 32'h0, "status reset");
    rdc(`FCVS_ADDR_MASK, 32'h0, "mask reset");
    rdc(`FCVS_ADDR_STATE, 32'h0, "state reset");
    feed(20'h0C350);
    chk(alarm, 1'b0, "alarm at rated");
    feed(20'h0BF04);
    chk(alarm, 1'b1, "alarm on pickup");
    chk(trip, 1'b0, "trip before limit");
    feed(20'h0BCAC);
    chk(trip, 1'b1, "trip at limit");
    rdc(`FCVS_ADDR_STATUS, 32'h3, "status events");
    apb(1'b1, `FCVS_ADDR_STATE, 32'hFFFFFFFF);
    rdc(`FCVS_ADDR_STATE, 32'h3A, "state view");
    @(negedge mclk_i);
    chk(irq, 1'b0, "irq masked");
    apb(1'b1, `FCVS_ADDR_MASK, 32'h2);
    @(negedge mclk_i);
    chk(irq, 1'b1, "irq unmasked");
    apb(1'b1, `FCVS_ADDR_STATUS, 32'h2);
    @(negedge mclk_i);
    chk(irq, 1'b0, "irq cleared");
    rdc(`FCVS_ADDR_STATUS, 32'h1, "status after clear");
    rdc(`FCVS_ADDR_MASK, 32'h2, "mask readback");
    rdc(12'h00C, 32'h0, "unmapped read");
    chk(er, 1'b1, "unmapped error");
    feed(20'h0C350);
    chk(trip, 1'b0, "trip released");
    // Interval runs out without the limit, element stays locked
    rst(FCVS_MODE_UNDER_DF, FCVS_PH_ALL, 20'h0BF68);
    feed(20'h0BF04);
    feed(20'h0BF72);
    chk(alarm, 1'b1, "held inside dropout");
    repeat (60) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(alarm, 1'b0, "alarm after expiry");
    rdc(`FCVS_ADDR_STATUS, 32'h5, "lock event");
    feed(20'h0BCAC);
    chk(trip, 1'b0, "no trip while locked");
    feed(20'h0C350);
    feed(20'h0BF04);
    chk(alarm, 1'b1, "new crossing alarms");
    // Blocking input and voltage supervision
    rst(FCVS_MODE_UNDER_DF, FCVS_PH_ALL, 20'h0BF68);
    blk <= 1'b1;
    feed(20'h0BF04);
    chk(alarm, 1'b0, "blocked pickup");
    rst(FCVS_MODE_OFF, FCVS_PH_ALL, 20'h0BF68);
    feed(20'h0BF04);
    chk(alarm, 1'b0, "element switched off");
    rst(FCVS_MODE_UNDER_DF, FCVS_PH_ALL, 20'h0BF68);
    meas.volt <= {16'h0800, 16'h0800, 16'h8000};
    feed(20'h0BF04);
    chk(alarm, 1'b1, "one voltage present");
    rst(FCVS_MODE_UNDER_DF, FCVS_PH_ALL, 20'h0BF68);
    meas.volt <= {3{16'h0800}};
    feed(20'h0BF04);
    chk(alarm, 1'b0, "all voltages low");
    // Overfrequency variant
    rst(FCVS_MODE_OVER_DF, FCVS_PH_ALL, 20'h0C738);
    feed(20'h0C79C);
    chk(alarm, 1'b1, "over pickup");
    feed(20'h0C72E);
    chk(alarm, 1'b1, "over dropout hold");
    feed(20'h0C9F4);
    chk(trip, 1'b1, "over trip");
    feed(20'h0C71C);
    chk(trip, 1'b0, "over dropout release");
    chk(alarm, 1'b0, "over alarm release");
    // Vector surge cases from the table
    for (int i = 0; i < 6; i++) begin
      rst(FCVS_MODE_SURGE, sps[i], 20'h0C350);
      meas.phase_lost <= slo[i];
      blk <= sbk[i];
      if (slw[i]) begin
        meas.volt <= {3{16'h0800}};
      end
      repeat (5) zc(3'h7, 40);
      @(negedge mclk_i);
      chk(trip, 1'b0, "steady cycles");
      zc(sjm[i], 30);
      repeat (2) @(posedge mclk_i);
      @(negedge mclk_i);
      chk(trip, sex[i], "surge trip");
      chk(alarm, sex[i], "surge alarm");
    end
    finish_test;
  end
endmodule
